// file: rtl/video_traffic_pkg.sv
// Constants shared by the traffic generator end, the DMA end and their link.
// Assumes one clock for both ends; all timing figures are counts of that clock.
package video_traffic_pkg;
   // Line and frame timing, in clocks
   localparam int H_BLANK = 280;
   localparam int H_ACTIVE = 1920;
   localparam int V_ACTIVE = 24;
   localparam int V_BLANK_CLKS = 2200;
   localparam int FRAME_CLKS = (V_ACTIVE + 1) * (H_BLANK + H_ACTIVE);
   // Frame period derived from the video clock rate and frame rate
   localparam int VID_CLK_HZ = 148_500_000;
   localparam int FRAME_RATE = 2700;
   localparam int FRAME_PERIOD_CLKS = VID_CLK_HZ / FRAME_RATE;
   localparam int BW_WINDOW_CLKS = 55_000;
   // Bandwidth arithmetic
   localparam int BYTES_PER_PIXEL = 4;
   localparam int MEM_BYTES_PER_BEAT = 8;
   localparam int BEATS_PER_MEM_BEAT = MEM_BYTES_PER_BEAT / BYTES_PER_PIXEL;
   localparam logic [31:0] BPS_PER_MEM_BEAT = 32'(MEM_BYTES_PER_BEAT * FRAME_RATE);
   localparam logic [31:0] EXPECTED_BPS = 32'(H_ACTIVE * BYTES_PER_PIXEL * V_ACTIVE * FRAME_RATE);
   // Limits of the memory side; only FRAME_BUFS is used, by the frame_buf wrap
   localparam int DMA_OUTSTANDING = 4;
   localparam int MEM_PORT_ACCEPT = 8;
   localparam int DMA_MAX_BURST = 32;
   localparam int MEM_MAX_BURST = 16;
   localparam int LINE_BUF_DEPTH = 1024;
   localparam int FRAME_BUFS = 3;
   // Stream and buffer geometry
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 16;
   // Configuration port map and source LFSR
   localparam int CFG_ADDR_W = 8;
   localparam logic [7:0] CFG_ADDR_HSIZE = 8'h04;
   localparam logic [7:0] CFG_ADDR_VSIZE = 8'h08;
   localparam logic [31:0] LFSR_SEED = 32'h1ace_b00c;
   localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;

   typedef enum logic [2:0] {
      CFG_HSIZE = 3'b001,
      CFG_VSIZE = 3'b010,
      CFG_DONE = 3'b100
   } cfg_state_e;

   typedef enum logic [3:0] {
      PH_IDLE = 4'b0001,
      PH_HBLANK = 4'b0010,
      PH_ACTIVE = 4'b0100,
      PH_VBLANK = 4'b1000
   } line_phase_e;
endpackage

// file: rtl/video_link_if.sv
// Link between the traffic generator end and the DMA end.
// Assumes both ends run on the clock given to the interface.
interface video_link_if (
   input wire logic clk
);
   logic fsync;
   logic cfg_valid;
   logic cfg_ready;
   logic [video_traffic_pkg::CFG_ADDR_W-1:0] cfg_addr;
   logic [31:0] cfg_data;
   logic s2m_tvalid;
   logic s2m_tready;
   logic [video_traffic_pkg::DATA_W-1:0] s2m_tdata;
   logic s2m_tlast;
   logic m2s_tvalid;
   logic m2s_tready;
   logic [video_traffic_pkg::DATA_W-1:0] m2s_tdata;
   logic m2s_tlast;
   logic mem_wvalid;
   logic mem_wready;
   logic mem_rvalid;
   logic mem_rready;

   modport gen_end (
      output fsync, cfg_valid, cfg_addr, cfg_data, s2m_tvalid, s2m_tdata, s2m_tlast, m2s_tready,
      input cfg_ready, s2m_tready, m2s_tvalid, m2s_tdata, m2s_tlast,
      input mem_wvalid, mem_wready, mem_rvalid, mem_rready
   );
   modport dma_end (
      input fsync, cfg_valid, cfg_addr, cfg_data, s2m_tvalid, s2m_tdata, s2m_tlast, m2s_tready,
      output cfg_ready, s2m_tready, m2s_tvalid, m2s_tdata, m2s_tlast,
      output mem_wvalid, mem_wready, mem_rvalid, mem_rready
   );
endinterface

// file: rtl/dma_stream_end.sv
// DMA end: takes configuration writes, sinks the outgoing stream into memory
// writes and sources the return stream from memory reads, two pixels per beat.
// Assumes the generator end keeps the line timing on the link.
module dma_stream_end (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link
   video_link_if.dma_end link,
   // Status
   output logic configured,
   output logic [15:0] hsize,
   output logic [15:0] vsize
);
   logic [15:0] hsize_q;
   logic [15:0] vsize_q;
   logic [1:0] seen_q;
   logic wpair_q;
   logic wbeat_q;
   logic rpair_q;
   logic rbeat_q;
   logic [15:0] rd_left_q;
   logic [15:0] col_q;
   logic [31:0] rdata_q;
   logic s2m_acc;
   logic m2s_acc;

   // Configuration is always accepted in the cycle it is offered
   assign link.cfg_ready = 1'b1;
   assign configured = &seen_q;
   assign hsize = hsize_q;
   assign vsize = vsize_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hsize_q <= 16'h0000;
         vsize_q <= 16'h0000;
         seen_q <= 2'h0;
      end else if (link.cfg_valid) begin
         if (link.cfg_addr == video_traffic_pkg::CFG_ADDR_HSIZE) begin
            hsize_q <= link.cfg_data[15:0];
            seen_q[0] <= 1'b1;
         end
         if (link.cfg_addr == video_traffic_pkg::CFG_ADDR_VSIZE) begin
            vsize_q <= link.cfg_data[15:0];
            seen_q[1] <= 1'b1;
         end
      end
   end

   // Write side: stream is accepted in every cycle once configured
   assign link.s2m_tready = configured;
   assign s2m_acc = link.s2m_tvalid && link.s2m_tready;
   assign link.mem_wvalid = wbeat_q;
   assign link.mem_wready = wbeat_q;

   // Two stream pixels make one memory beat
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wpair_q <= 1'b0;
         wbeat_q <= 1'b0;
      end else begin
         wbeat_q <= s2m_acc && wpair_q;
         if (s2m_acc) begin
            wpair_q <= !wpair_q;
         end
      end
   end

   // Read side: one frame of pixels per frame sync
   assign m2s_acc = link.m2s_tvalid && link.m2s_tready;
   assign link.m2s_tvalid = (rd_left_q != 16'h0000);
   assign link.m2s_tdata = rdata_q;
   assign link.m2s_tlast = (col_q == hsize_q - 16'h0001);
   assign link.mem_rvalid = rbeat_q;
   assign link.mem_rready = rbeat_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_left_q <= 16'h0000;
         col_q <= 16'h0000;
         rdata_q <= 32'h0000_0000;
         rpair_q <= 1'b0;
         rbeat_q <= 1'b0;
      end else begin
         rbeat_q <= m2s_acc && rpair_q;
         if (link.fsync && configured) begin
            rd_left_q <= 16'(32'(hsize_q) * 32'(vsize_q));
            col_q <= 16'h0000;
            rpair_q <= 1'b0;
         end else if (m2s_acc) begin
            rd_left_q <= rd_left_q - 16'h0001;
            col_q <= link.m2s_tlast ? 16'h0000 : col_q + 16'h0001;
            rdata_q <= rdata_q + 32'h0000_0001;
            rpair_q <= !rpair_q;
         end
      end
   end
endmodule

// file: rtl/video_traffic_gen.sv
// Video traffic generator end: configures the DMA end, issues frame sync,
// sources and sinks the line streams and measures memory port bandwidth.
// Assumes the DMA end answers on the shared link and runs on the same clock.

// Stream FIFO with valid and ready on both sides
module stream_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid = (wr_q != rd_q);
   assign out_data = mem_q[rd_q[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

module video_traffic_gen #(
   parameter int FRAME_PERIOD = video_traffic_pkg::FRAME_PERIOD_CLKS,
   parameter int BW_WINDOW = video_traffic_pkg::BW_WINDOW_CLKS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link
   video_link_if.gen_end link,
   // Throttle flags
   input wire logic throttle_clr,
   output logic src_throttle,
   output logic snk_throttle,
   // Progress
   output logic cfg_done,
   output logic [4:0] lines_rx,
   output logic [1:0] frame_buf,
   // Bandwidth results
   output logic bw_valid,
   output logic [31:0] rd_bps,
   output logic [31:0] wr_bps,
   output logic rd_low,
   output logic wr_low
);
   video_traffic_pkg::cfg_state_e cfg_q;
   video_traffic_pkg::line_phase_e ph_q;
   logic [7:0] cfg_addr_q;
   logic [31:0] cfg_data_q;
   logic [15:0] fcnt_q;
   logic fsync_q;
   logic [11:0] pix_q;
   logic [4:0] line_q;
   logic [15:0] owed_q;
   logic [10:0] gpix_q;
   logic [31:0] lfsr_q;
   logic gen_valid;
   logic gen_ready;
   logic gen_push;
   logic line_start;
   logic [4:0] lines_rx_q;
   logic [1:0] fb_q;
   logic src_thr_q;
   logic snk_thr_q;
   logic bw_run_q;
   logic [15:0] win_q;
   logic [15:0] rd_cnt_q;
   logic [15:0] wr_cnt_q;
   logic bw_valid_q;
   logic [31:0] rd_bps_q;
   logic [31:0] wr_bps_q;
   logic [31:0] rd_sum;
   logic [31:0] wr_sum;

   // Configuration master: size writes first
   assign cfg_done = (cfg_q == video_traffic_pkg::CFG_DONE);
   assign link.cfg_valid = !cfg_done;
   assign link.cfg_addr = cfg_addr_q;
   assign link.cfg_data = cfg_data_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_q <= video_traffic_pkg::CFG_HSIZE;
         cfg_addr_q <= video_traffic_pkg::CFG_ADDR_HSIZE;
         cfg_data_q <= 32'(video_traffic_pkg::H_ACTIVE);
      end else begin
         unique case (cfg_q)
            video_traffic_pkg::CFG_HSIZE: begin
               if (link.cfg_ready) begin
                  cfg_q <= video_traffic_pkg::CFG_VSIZE;
                  cfg_addr_q <= video_traffic_pkg::CFG_ADDR_VSIZE;
                  cfg_data_q <= 32'(video_traffic_pkg::V_ACTIVE);
               end
            end
            video_traffic_pkg::CFG_VSIZE: begin
               if (link.cfg_ready) begin
                  cfg_q <= video_traffic_pkg::CFG_DONE;
               end
            end
            video_traffic_pkg::CFG_DONE: begin
               cfg_q <= video_traffic_pkg::CFG_DONE;
            end
         endcase
      end
   end

   // Frame sync every FRAME_PERIOD clocks once configured
   assign link.fsync = fsync_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fcnt_q <= 16'h0000;
         fsync_q <= 1'b0;
      end else begin
         fsync_q <= cfg_done && (fcnt_q == 16'h0000);
         if (!cfg_done || fcnt_q == 16'(FRAME_PERIOD - 1)) begin
            fcnt_q <= 16'h0000;
         end else begin
            fcnt_q <= fcnt_q + 16'h0001;
         end
      end
   end

   // Line timing after each sync
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ph_q <= video_traffic_pkg::PH_IDLE;
         pix_q <= 12'h000;
         line_q <= 5'h00;
      end else if (fsync_q) begin
         ph_q <= video_traffic_pkg::PH_HBLANK;
         pix_q <= 12'h000;
         line_q <= 5'h00;
      end else begin
         pix_q <= pix_q + 12'h001;
         unique case (ph_q)
            video_traffic_pkg::PH_IDLE: begin
               pix_q <= 12'h000;
            end
            video_traffic_pkg::PH_HBLANK: begin
               if (pix_q == 12'(video_traffic_pkg::H_BLANK - 1)) begin
                  ph_q <= video_traffic_pkg::PH_ACTIVE;
                  pix_q <= 12'h000;
               end
            end
            video_traffic_pkg::PH_ACTIVE: begin
               if (pix_q == 12'(video_traffic_pkg::H_ACTIVE - 1)) begin
                  pix_q <= 12'h000;
                  line_q <= line_q + 5'h01;
                  if (line_q == 5'(video_traffic_pkg::V_ACTIVE - 1)) begin
                     ph_q <= video_traffic_pkg::PH_VBLANK;
                  end else begin
                     ph_q <= video_traffic_pkg::PH_HBLANK;
                  end
               end
            end
            video_traffic_pkg::PH_VBLANK: begin
               if (pix_q == 12'(video_traffic_pkg::V_BLANK_CLKS - 1)) begin
                  ph_q <= video_traffic_pkg::PH_IDLE;
               end
            end
         endcase
      end
   end

   // Source: owes one line of beats per active line, stalls on a full FIFO
   assign line_start = (ph_q == video_traffic_pkg::PH_HBLANK) &&
                       (pix_q == 12'(video_traffic_pkg::H_BLANK - 1));
   assign gen_valid = (owed_q != 16'h0000);
   assign gen_push = gen_valid && gen_ready;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         owed_q <= 16'h0000;
         gpix_q <= 11'h000;
         lfsr_q <= video_traffic_pkg::LFSR_SEED;
      end else begin
         owed_q <= owed_q + (line_start ? 16'(video_traffic_pkg::H_ACTIVE) : 16'h0000)
                   - {15'h0000, gen_push};
         if (gen_push) begin
            gpix_q <= (gpix_q == 11'(video_traffic_pkg::H_ACTIVE - 1)) ? 11'h000 : gpix_q + 11'h001;
            lfsr_q <= {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? video_traffic_pkg::LFSR_TAPS : 32'h0000_0000);
         end
      end
   end

   stream_fifo #(
      .WIDTH(video_traffic_pkg::DATA_W + 1),
      .DEPTH(video_traffic_pkg::FIFO_DEPTH)
   ) src_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(gen_valid),
      .in_ready(gen_ready),
      .in_data({gpix_q == 11'(video_traffic_pkg::H_ACTIVE - 1), lfsr_q}),
      .out_valid(link.s2m_tvalid),
      .out_ready(link.s2m_tready),
      .out_data({link.s2m_tlast, link.s2m_tdata})
   );

   // Sink: ready through the active window, lines counted on end-of-packet
   assign link.m2s_tready = (ph_q == video_traffic_pkg::PH_ACTIVE);
   assign lines_rx = lines_rx_q;
   assign frame_buf = fb_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lines_rx_q <= 5'h00;
         fb_q <= 2'h0;
      end else if (fsync_q) begin
         lines_rx_q <= 5'h00;
         fb_q <= (fb_q == 2'(video_traffic_pkg::FRAME_BUFS - 1)) ? 2'h0 : fb_q + 2'h1;
      end else if (link.m2s_tvalid && link.m2s_tready && link.m2s_tlast) begin
         lines_rx_q <= lines_rx_q + 5'h01;
      end
   end

   // Throttle flags; a new event wins over a clear
   assign src_throttle = src_thr_q;
   assign snk_throttle = snk_thr_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         src_thr_q <= 1'b0;
         snk_thr_q <= 1'b0;
      end else begin
         src_thr_q <= (src_thr_q && !throttle_clr) || ((ph_q == video_traffic_pkg::PH_ACTIVE) &&
                      link.s2m_tready && !link.s2m_tvalid);
         snk_thr_q <= (snk_thr_q && !throttle_clr) ||
                      (link.m2s_tready && !link.m2s_tvalid);
      end
   end

   // Bandwidth monitor on the memory port, one result per window
   assign rd_sum = 32'(rd_cnt_q) + {31'h0000_0000, link.mem_rvalid && link.mem_rready};
   assign wr_sum = 32'(wr_cnt_q) + {31'h0000_0000, link.mem_wvalid && link.mem_wready};
   assign bw_valid = bw_valid_q;
   assign rd_bps = rd_bps_q;
   assign wr_bps = wr_bps_q;
   assign rd_low = bw_valid_q && (rd_bps_q < video_traffic_pkg::EXPECTED_BPS);
   assign wr_low = bw_valid_q && (wr_bps_q < video_traffic_pkg::EXPECTED_BPS);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bw_run_q <= 1'b0;
         win_q <= 16'h0000;
         rd_cnt_q <= 16'h0000;
         wr_cnt_q <= 16'h0000;
         bw_valid_q <= 1'b0;
         rd_bps_q <= 32'h0000_0000;
         wr_bps_q <= 32'h0000_0000;
      end else if (!bw_run_q) begin
         bw_run_q <= fsync_q;
      end else if (win_q == 16'(BW_WINDOW - 1)) begin
         win_q <= 16'h0000;
         rd_cnt_q <= 16'h0000;
         wr_cnt_q <= 16'h0000;
         bw_valid_q <= 1'b1;
         rd_bps_q <= rd_sum * video_traffic_pkg::BPS_PER_MEM_BEAT;
         wr_bps_q <= wr_sum * video_traffic_pkg::BPS_PER_MEM_BEAT;
      end else begin
         win_q <= win_q + 16'h0001;
         rd_cnt_q <= rd_sum[15:0];
         wr_cnt_q <= wr_sum[15:0];
      end
   end
endmodule

// file: testbench/video_link_props.sv
// Concurrent checks on the link between the traffic generator end and the DMA end.
// Assumes the bench instantiates it beside the link and drives one active-low reset.
module video_link_props #(
   parameter int FRAME_PERIOD = video_traffic_pkg::FRAME_PERIOD_CLKS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Configuration and sync
   input wire logic fsync,
   input wire logic cfg_valid,
   input wire logic cfg_ready,
   input wire logic [video_traffic_pkg::CFG_ADDR_W-1:0] cfg_addr,
   input wire logic [31:0] cfg_data,
   // Streams
   input wire logic s2m_tvalid,
   input wire logic s2m_tready,
   input wire logic s2m_tlast,
   input wire logic m2s_tvalid,
   input wire logic m2s_tready,
   input wire logic m2s_tlast,
   // Memory port
   input wire logic mem_wvalid,
   input wire logic mem_wready,
   input wire logic mem_rvalid,
   input wire logic mem_rready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   logic [31:0] age_q;
   logic seen_q;
   logic [10:0] s2m_beat_q;
   logic [10:0] m2s_beat_q;
   logic [31:0] pos;
   logic in_lines;
   assign pos = age_q % 32'h898;
   assign in_lines = seen_q && age_q < 32'hce40;

   // Cycles since the last frame sync
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         age_q <= '0;
         seen_q <= 1'b0;
      end else if (fsync) begin
         age_q <= '0;
         seen_q <= 1'b1;
      end else begin
         age_q <= age_q + 32'h1;
      end
   end

   // Beats taken so far in the current line
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s2m_beat_q <= '0;
      end else if (s2m_tvalid && s2m_tready) begin
         s2m_beat_q <= s2m_tlast ? 11'h0 : s2m_beat_q + 11'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         m2s_beat_q <= '0;
      end else if (m2s_tvalid && m2s_tready) begin
         m2s_beat_q <= m2s_tlast ? 11'h0 : m2s_beat_q + 11'h1;
      end
   end

   sequence hsize_wr;
      cfg_valid && cfg_ready && cfg_addr == video_traffic_pkg::CFG_ADDR_HSIZE && cfg_data == 32'h780;
   endsequence
   sequence vsize_wr;
      cfg_valid && cfg_ready && cfg_addr == video_traffic_pkg::CFG_ADDR_VSIZE && cfg_data == 32'h18;
   endsequence

   a_cfg_write_order: assert property ($rose(rstn) |-> hsize_wr ##1 vsize_wr ##1 !cfg_valid[*8])
      else $error("configuration writes out of order");
   a_sync_after_cfg: assert property (fsync |-> !cfg_valid)
      else $error("frame sync before configuration ended");
   a_sync_period: assert property (fsync && seen_q |-> age_q == 32'(FRAME_PERIOD - 1) ##1 !fsync)
      else $error("frame sync spacing wrong");
   a_hblank_quiet: assert property (in_lines && pos < 32'h118 |-> !m2s_tready)
      else $error("stream active during line blanking");
   a_active_ready: assert property (in_lines && pos >= 32'h118 |-> m2s_tready && m2s_tvalid)
      else $error("stream idle during active line");
   a_vblank_quiet: assert property (seen_q && age_q >= 32'hce40 && age_q < 32'hd6d8 |-> !m2s_tready)
      else $error("stream active during blank line");
   a_s2m_line_len: assert property (s2m_tvalid && s2m_tready && s2m_tlast |-> s2m_beat_q == 11'h77f)
      else $error("outgoing line length wrong");
   a_m2s_line_len: assert property (m2s_tvalid && m2s_tready && m2s_tlast |-> m2s_beat_q == 11'h77f)
      else $error("returning line length wrong");
   a_mem_wr_pair: assert property (s2m_tvalid && s2m_tready && s2m_beat_q[0] |=> mem_wvalid && mem_wready)
      else $error("memory write beat missing");
   a_mem_rd_pair: assert property (m2s_tvalid && m2s_tready && m2s_beat_q[0] |=> mem_rvalid && mem_rready)
      else $error("memory read beat missing");
endmodule

// file: testbench/test_video_traffic_timing_monitor.sv
// Bench joining both ends over the link; the stream FIFO is reached through the generator.
// Assumes the design files are compiled first; one clock at 125 MHz.
module test_video_traffic_timing_monitor;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PERIOD = 55000;
   logic clk;
   logic rstn = 1'b0;
   logic throttle_clr = 1'b0;
   logic src_throttle, snk_throttle, cfg_done, bw_valid, rd_low, wr_low, configured;
   logic [4:0] lines_rx;
   logic [1:0] frame_buf;
   logic [31:0] rd_bps, wr_bps;
   logic [15:0] hsize, vsize;
   logic [31:0] exp_lfsr = video_traffic_pkg::LFSR_SEED;
   int s2m_beats = 0;
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;
   int sync_cnt = 0;
   int sync_cyc[2];
   int bw_cyc = 0;
   int s2m_lines = 0;
   int i;
   logic early_sync = 1'b0;
   logic [1:0] fb0;

   video_link_if video_link_if_i (.clk(clk));
   dma_stream_end dma_stream_end_i (.clk(clk), .rstn(rstn), .link(video_link_if_i), .configured(configured),
      .hsize(hsize), .vsize(vsize));
   video_traffic_gen #(.FRAME_PERIOD(PERIOD), .BW_WINDOW(PERIOD)) video_traffic_gen_i (.clk(clk), .rstn(rstn),
      .link(video_link_if_i), .throttle_clr(throttle_clr), .src_throttle(src_throttle), .snk_throttle(snk_throttle),
      .cfg_done(cfg_done), .lines_rx(lines_rx), .frame_buf(frame_buf), .bw_valid(bw_valid), .rd_bps(rd_bps),
      .wr_bps(wr_bps), .rd_low(rd_low), .wr_low(wr_low));
   video_link_props #(.FRAME_PERIOD(PERIOD)) video_link_props_i (.clk(clk), .rstn(rstn),
      .fsync(video_link_if_i.fsync), .cfg_valid(video_link_if_i.cfg_valid), .cfg_ready(video_link_if_i.cfg_ready),
      .cfg_addr(video_link_if_i.cfg_addr), .cfg_data(video_link_if_i.cfg_data),
      .s2m_tvalid(video_link_if_i.s2m_tvalid), .s2m_tready(video_link_if_i.s2m_tready),
      .s2m_tlast(video_link_if_i.s2m_tlast), .m2s_tvalid(video_link_if_i.m2s_tvalid),
      .m2s_tready(video_link_if_i.m2s_tready), .m2s_tlast(video_link_if_i.m2s_tlast),
      .mem_wvalid(video_link_if_i.mem_wvalid), .mem_wready(video_link_if_i.mem_wready),
      .mem_rvalid(video_link_if_i.mem_rvalid), .mem_rready(video_link_if_i.mem_rready));

   function automatic logic [31:0] exp_bps();
      return 32'(1920 * 4 * 24 * 2700);
   endfunction

   function automatic logic [31:0] next_lfsr(logic [31:0] v);
      return {v[30:0], 1'b0} ^ (v[31] ? video_traffic_pkg::LFSR_TAPS : 32'h0000_0000);
   endfunction

   function automatic int exp_period();
      return 148_500_000 / 2700;
   endfunction

   task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Frame sync, line end and result events on the link
   always @(posedge clk) begin
      cyc++;
      if (video_link_if_i.fsync === 1'b1) begin
         if (cfg_done !== 1'b1) early_sync = 1'b1;
         if (sync_cnt < 2) sync_cyc[sync_cnt] = cyc;
         sync_cnt++;
      end
      if (video_link_if_i.s2m_tvalid === 1'b1 && video_link_if_i.s2m_tready === 1'b1) begin
         check("s2m data", video_link_if_i.s2m_tdata, exp_lfsr);
         exp_lfsr = next_lfsr(exp_lfsr);
         s2m_beats++;
      end
      if (video_link_if_i.s2m_tvalid && video_link_if_i.s2m_tready && video_link_if_i.s2m_tlast) s2m_lines++;
      if (bw_valid === 1'b1 && bw_cyc == 0) bw_cyc = cyc;
   end

   initial begin
      #(8 * 70000);
      $display("watchdog expired at cycle %0d", cyc);
      miscompares++;
      summarize();
   end

   initial begin
      void'($urandom(75));
      repeat (8) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      for (i = 0; i < 10 && cfg_done !== 1'b1; i++) @(negedge clk);
      check("cfg_done", cfg_done, 1'b1);
      check("hsize", hsize, 16'h780);
      check("vsize", vsize, 16'h18);
      check("configured", configured, 1'b1);
      while (sync_cnt == 0 || cyc < sync_cyc[0] + 53000) @(negedge clk);
      check("s2m beats", s2m_beats, 1920 * 24);
      check("s2m drained", video_link_if_i.s2m_tvalid, 1'b0);
      check("early sync", early_sync, 1'b0);
      check("lines_rx", lines_rx, 5'h18);
      check("s2m lines", s2m_lines, 24);
      check("snk_throttle", snk_throttle, 1'b0);
      fb0 = frame_buf;
      throttle_clr = 1'b1;
      repeat ($urandom_range(1, 4)) @(negedge clk);
      throttle_clr = 1'b0;
      @(negedge clk);
      check("src_throttle", src_throttle, 1'b0);
      while (bw_cyc == 0) @(negedge clk);
      check("window end", (bw_cyc - sync_cyc[0]) inside {[55000:55004]}, 1'b1);
      check("wr_bps", wr_bps, exp_bps());
      check("rd_bps", rd_bps, exp_bps());
      check("wr_low", wr_low, 1'b0);
      check("rd_low", rd_low, 1'b0);
      while (sync_cnt < 2) @(negedge clk);
      repeat (3) @(negedge clk);
      check("sync period", sync_cyc[1] - sync_cyc[0], exp_period());
      check("lines_rx cleared", lines_rx, 5'h0);
      check("frame_buf", frame_buf, 2'((fb0 + 2'h1) % 3));
      summarize();
   end
endmodule
